// file: logic/bdm_dec_if.sv
// interface: decoded access between the top and the ram array
`timescale 1ns/100ps
interface bdm_dec_if;
  logic       we;
  logic [6:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport dec (output we, output idx, output wdata, input rdata);
  modport ram (input we, input idx, input wdata, output rdata);
endinterface : bdm_dec_if

// file: logic/bdm_pkg.sv
// package: address map constants and types of the banked data memory
package bdm_pkg;
  localparam int          DATA_W       = 8;
  localparam int          INSTR_W      = 14;
  localparam int          DIR_W        = 7;
  localparam int          ADDR_W       = 8;
  localparam int          BANK_BIT_POS = 5;
  localparam int          SFR_COUNT    = 32;
  localparam logic [6:0]  SFR_LAST     = 7'h1f;
  localparam logic [6:0]  GPR0_FIRST   = 7'h20;
  localparam logic [6:0]  GPR0_LAST    = 7'h7f;
  localparam logic [7:0]  GPR1_FIRST   = 8'ha0;
  localparam logic [7:0]  GPR1_LAST    = 8'hbf;
  localparam logic [7:0]  SHARE_FIRST  = 8'hf0;
  localparam logic [7:0]  SHARE_LAST   = 8'hff;
  localparam logic [7:0]  SHARE_MIRROR = 8'h70;
  localparam int          RAM_WORDS    = 128;
  // bank 1 cells sit below the bank 0 cells so the two never alias
  localparam logic [6:0]  RAM_IDX_B1   = 7'h00;
  localparam logic [7:0]  RESET_DATA   = 8'h00;

  // variant of the part the decoder serves
  typedef enum logic [1:0] {
    BDM_RAM96,
    BDM_RAM128
  } bdm_variant_t;

  // where a full data address lands
  typedef enum logic [1:0] {
    BDM_HIT_SFR,
    BDM_HIT_RAM,
    BDM_HIT_NONE
  } bdm_hit_t;
endpackage : bdm_pkg

// file: logic/bdm_ram.sv
// module: static ram array holding the general purpose registers
`timescale 1ns/100ps
module bdm_ram (
  input wire logic clk,
  input wire logic rst_b,
  bdm_dec_if.ram   port
);
  typedef struct packed {
    logic [7:0] rdata;
  } bdm_ram_st_t;

  // the array itself is kept out of the state struct; ram has no reset
  logic [7:0]  mem [0:bdm_pkg::RAM_WORDS-1];
  bdm_ram_st_t st_r;
  bdm_ram_st_t st_nxt;

  // read data registered so the data output comes from a flip-flop
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = mem[port.idx];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '{rdata: bdm_pkg::RESET_DATA};
    end else begin
      st_r <= st_nxt;
    end
    if (port.we) begin
      mem[port.idx] <= port.wdata;
    end
  end

  assign port.rdata = st_r.rdata;
endmodule : bdm_ram

// file: logic/bdm_top.sv
// module: bank decoder for the data memory of a small 8-bit controller
// What this block does
// - direct access: bank-select bit clear picks bank 0, set picks bank 1; indirect access takes the bank from pointer bit 7
// - lowest 32 locations of each bank go to special function registers
// - 96-byte variants: bank 0 20h-7Fh is general purpose static ram
// - 128-byte variant adds bank 1 A0h-BFh as general purpose ram
// - bank 1 F0h-FFh reach the same cells as bank 0 70h-7Fh
// - data locations are 8 bits, separate from 14-bit program words
// - ram reachable directly and through the indirect pointer register
`timescale 1ns/100ps
module bdm_top (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire bdm_pkg::bdm_variant_t variant,
  input  wire logic [7:0]          status_value,
  input  wire logic                use_indirect,
  input  wire logic [6:0]          direct_addr,
  input  wire logic [7:0]          indirect_pointer_register,
  input  wire logic                rd_en,
  input  wire logic                wr_en,
  input  wire logic [7:0]          wr_data,
  input  wire logic [7:0]          sfr_rdata,
  output logic                     sfr_rd,
  output logic                     sfr_wr,
  output logic [4:0]               sfr_addr,
  output logic                     sfr_bank,
  output logic [7:0]               sfr_wdata,
  output logic [7:0]               rd_data,
  output logic                     rd_valid,
  output logic [7:0]               full_addr
);
  typedef struct packed {
    logic                rd_valid;
    bdm_pkg::bdm_hit_t   hit;
    logic [7:0]          full_addr;
    logic                sfr_rd;
    logic                sfr_wr;
    logic [4:0]          sfr_addr;
    logic                sfr_bank;
    logic [7:0]          sfr_wdata;
  } bdm_st_t;

  bdm_st_t    st_r;
  bdm_st_t    st_nxt;
  bdm_dec_if  ram_if ();

  logic [7:0] addr;
  logic [6:0] ram_idx;
  bdm_pkg::bdm_hit_t hit;

  // classify a full address for the given variant
  function automatic bdm_pkg::bdm_hit_t classify(
    input logic [7:0]            a,
    input bdm_pkg::bdm_variant_t v
  );
    bdm_pkg::bdm_hit_t r;
    r = bdm_pkg::BDM_HIT_NONE;
    if (a[6:0] <= bdm_pkg::SFR_LAST) begin
      r = bdm_pkg::BDM_HIT_SFR;
    end else if (!a[7]) begin
      r = bdm_pkg::BDM_HIT_RAM;
    end else if (a >= bdm_pkg::SHARE_FIRST) begin
      r = bdm_pkg::BDM_HIT_RAM;
    end else if (v == bdm_pkg::BDM_RAM128 && a >= bdm_pkg::GPR1_FIRST
                 && a <= bdm_pkg::GPR1_LAST) begin
      r = bdm_pkg::BDM_HIT_RAM;
    end
    return r;
  endfunction : classify

  // map a ram address onto the physical cell index
  function automatic logic [6:0] ram_index(input logic [7:0] a);
    logic [6:0] r;
    r = a[6:0];
    if (a >= bdm_pkg::SHARE_FIRST) begin
      r = {3'h7, a[3:0]}; // shares 70h-7Fh cells
    end else if (a[7]) begin
      r = a[6:0] - bdm_pkg::GPR1_FIRST[6:0] + bdm_pkg::RAM_IDX_B1;
    end
    return r;
  endfunction : ram_index

  // address forming: the indirect path carries its own bank bit, direct
  // path takes the bank-select bit of the status value
  always_comb begin
    if (use_indirect) begin
      addr = indirect_pointer_register;
    end else begin
      addr = {status_value[bdm_pkg::BANK_BIT_POS], direct_addr};
    end
    hit     = classify(addr, variant);
    ram_idx = ram_index(addr);
  end

  // ram is written only on a ram hit; unmapped writes fall away
  assign ram_if.we    = wr_en && hit == bdm_pkg::BDM_HIT_RAM;
  assign ram_if.idx   = ram_idx;
  assign ram_if.wdata = wr_data;

  bdm_ram u_ram (
    .clk   (clk),
    .rst_b (rst_b),
    .port  (ram_if.ram)
  );

  // next state: register the access so every output except rd_data comes from flip-flops
  always_comb begin
    st_nxt           = st_r;
    st_nxt.rd_valid  = rd_en;
    st_nxt.hit       = hit;
    st_nxt.full_addr = addr;
    st_nxt.sfr_rd    = rd_en && hit == bdm_pkg::BDM_HIT_SFR;
    st_nxt.sfr_wr    = wr_en && hit == bdm_pkg::BDM_HIT_SFR;
    st_nxt.sfr_addr  = addr[4:0];
    st_nxt.sfr_bank  = addr[7];
    st_nxt.sfr_wdata = wr_data;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '{rd_valid: 1'b0, hit: bdm_pkg::BDM_HIT_NONE,
                full_addr: 8'h00, sfr_rd: 1'b0, sfr_wr: 1'b0,
                sfr_addr: 5'h00, sfr_bank: 1'b0,
                sfr_wdata: bdm_pkg::RESET_DATA};
    end else begin
      st_r <= st_nxt;
    end
  end

  // read mux one cycle after the request; holes read zero
  always_comb begin
    rd_data = bdm_pkg::RESET_DATA;
    if (st_r.rd_valid && st_r.hit == bdm_pkg::BDM_HIT_RAM) begin
      rd_data = ram_if.rdata;
    end else if (st_r.rd_valid && st_r.hit == bdm_pkg::BDM_HIT_SFR) begin
      rd_data = sfr_rdata;
    end
  end

  assign rd_valid  = st_r.rd_valid;
  assign full_addr = st_r.full_addr;
  assign sfr_rd    = st_r.sfr_rd;
  assign sfr_wr    = st_r.sfr_wr;
  assign sfr_addr  = st_r.sfr_addr;
  assign sfr_bank  = st_r.sfr_bank;
  assign sfr_wdata = st_r.sfr_wdata;
endmodule : bdm_top

// file: tb/bdm_sfr_model.sv
// special function register block answering the decoder
`timescale 1ns/100ps
module bdm_sfr_model (
  input  wire logic       clk,
  input  wire logic       sfr_rd,
  input  wire logic       sfr_bank,
  input  wire logic [4:0] sfr_addr,
  output logic      [7:0] sfr_rdata
);
  logic [7:0] last_r;
  // value tells bank and offset apart; idle shows inverse, never stale
  always_ff @(posedge clk) last_r <= sfr_rdata;
  assign sfr_rdata = sfr_rd ? {2'h2, sfr_bank, sfr_addr} : ~last_r;
endmodule : bdm_sfr_model

// file: tb/bdm_top_props.sv
// checker: port level assertions of the bank decoder
`timescale 1ns/100ps
module bdm_chk (
  input wire logic                  clk, rst_b, rd_en, wr_en,
  input wire logic                  use_indirect, sfr_rd, rd_valid,
  input wire logic                  sfr_bank,
  input wire bdm_pkg::bdm_variant_t variant,
  input wire logic [7:0]            status_value, full_addr, rd_data,
  input wire logic [7:0]            indirect_pointer_register, sfr_rdata,
  input wire logic [6:0]            direct_addr,
  input wire logic [4:0]            sfr_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rq = rd_en | wr_en;
  wire bsel = status_value[5];
  read_answer_a: assert property (rd_en |=> rd_valid)
    else $error("read not answered");
  bank_addr_a: assert property (rq && !use_indirect |=>
    full_addr == {$past(bsel), $past(direct_addr)}) else $error("bank addr");
  ind_addr_a: assert property (rq && use_indirect |=>
    full_addr == $past(indirect_pointer_register)) else $error("ptr addr");
  sfr_route_a: assert property (rd_valid && full_addr[6:5] == 2'h0 |->
    sfr_rd && sfr_addr == full_addr[4:0] && sfr_bank == full_addr[7])
    else $error("sfr route");
  sfr_data_a: assert property (sfr_rd |-> rd_data == sfr_rdata)
    else $error("sfr data");
  hole_zero_a: assert property (rd_valid && full_addr[7:6] == 2'h3 &&
    full_addr[5:4] != 2'h3 |-> rd_data == 8'h00) else $error("hole data");
  small_var_a: assert property (rd_valid && full_addr[7:5] == 3'h5 &&
    variant == bdm_pkg::BDM_RAM96 |-> rd_data == 8'h00) else $error("a0 ram");
  idle_zero_a: assert property (!rd_valid |-> rd_data == 8'h00)
    else $error("idle data");
endmodule : bdm_chk
bind bdm_top bdm_chk i_chk (.*);

// file: tb/bdm_top_tb.sv
// testbench: decoder driven by direct and indirect accesses
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module bdm_top_tb;
  logic clk = 0, rst_b = 0, ui = 0, rd_en = 0, wr_en = 0;
  logic sfr_rd, sfr_bank, rd_valid, sfr_wr;
  logic [7:0] st = 0, ip = 0, wd = 0, sfr_rdata, rd_data, full_addr;
  logic [7:0] sfr_wdata;
  logic [6:0] da = 0;
  logic [4:0] sfr_addr;
  bdm_pkg::bdm_variant_t variant = bdm_pkg::BDM_RAM96;
  int bad_count = 0;
  int n_checks = 0;
  bdm_top i_dut (.clk, .rst_b, .variant, .status_value(st),
    .use_indirect(ui), .direct_addr(da), .indirect_pointer_register(ip),
    .rd_en, .wr_en, .wr_data(wd), .sfr_rdata, .sfr_rd, .sfr_wr,
    .sfr_addr, .sfr_bank, .sfr_wdata, .rd_data, .rd_valid, .full_addr);
  bdm_sfr_model i_sfr (.clk, .sfr_rd, .sfr_bank, .sfr_addr, .sfr_rdata);
  initial begin
    forever #5 clk = ~clk;
  end
  // one request; status bank is wrong on purpose when the pointer is used
  task automatic acc(input logic w, ind, input logic [7:0] a, d);
    @(posedge clk);
    rd_en <= !w;
    wr_en <= w;
    ui <= ind;
    ip <= a;
    wd <= d;
    st <= {2'h0, a[7] ^ ind, 5'h00};
    da <= a[6:0];
    @(posedge clk);
    rd_en <= 0;
    wr_en <= 0;
    #1;
  endtask : acc
  task automatic rd(input logic ind, input logic [7:0] a, e);
    acc(0, ind, a, 8'h00);
    `CHK("rd_data", e, rd_data)
  endtask : rd
  task t_small;
    acc(1, 1, 8'h25, 8'h55);
    rd(0, 8'h25, 8'h55);
    acc(1, 0, 8'h73, 8'h3c);
    rd(1, 8'hf3, 8'h3c);
    acc(1, 1, 8'hff, 8'hff);
    rd(0, 8'h7f, 8'hff);
    acc(1, 0, 8'ha0, 8'h99);
    rd(0, 8'ha0, 8'h00);
    $display("small variant done");
  endtask : t_small
  task t_big;
    variant <= bdm_pkg::BDM_RAM128;
    acc(1, 0, 8'h65, 8'h11);
    acc(1, 1, 8'ha5, 8'h77);
    rd(0, 8'ha5, 8'h77);
    rd(0, 8'h65, 8'h11);
    acc(1, 0, 8'hc4, 8'h12);
    rd(1, 8'hc4, 8'h00);
    $display("large variant done");
  endtask : t_big
  task t_sfr;
    rd(0, 8'h05, 8'h85);
    `CHK("sfr_addr", 5'h05, sfr_addr)
    rd(1, 8'h9f, 8'hbf);
    `CHK("sfr_bank", 1'b1, sfr_bank)
    $display("sfr space done");
  endtask : t_sfr
  // a write into bank 1 special space goes out on the sfr port only
  task t_sfr_wr;
    acc(1, 0, 8'h8c, 8'h5a);
    `CHK("sfr_wr", 1'b1, sfr_wr)
    `CHK("sfr_wdata", 8'h5a, sfr_wdata)
    `CHK("sfr_bank", 1'b1, sfr_bank)
    `CHK("full_addr", 8'h8c, full_addr)
    acc(1, 0, 8'h40, 8'h21);
    `CHK("sfr_wr", 1'b0, sfr_wr)
    $display("sfr write done");
  endtask : t_sfr_wr
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1;
    t_small();
    t_big();
    t_sfr();
    t_sfr_wr();
    complete_run();
  end
endmodule : bdm_top_tb
